// File: core/amc_config_regs.sv
// mode and clock configuration bank with apb slave and ready pin control
// assumes sample strobes and service pulse come from logic on clk
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module amc_config_regs (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [7:0]        sampleStrobe,
    input  wire logic              dataServiced,
    output amc_pkg::amc_mode_t     modeCfg,
    output logic      [7:0]        channelEnable,
    output logic                   dataReadyPinOut,
    output logic                   dataReadyPinOe,
    output logic                   irq
);
    import amc_pkg::*;

    localparam int PulseLen = READY_PULSE_CYCLES;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function automatic logic [7:0] regIndex(input logic [31:0] a);
        regIndex = a[9:2];
    endfunction : regIndex

    function automatic logic readyPending(input logic [1:0] sel,
                                          input logic [7:0] flags,
                                          input logic [7:0] en);
        logic [7:0] act;
        act = flags & en;
        case (sel)
            SRC_LAGGING: readyPending = (en != 8'h00) && (act == en);
            SRC_OR:      readyPending = |act;
            default:     readyPending = |act;
        endcase
    endfunction : readyPending

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic        [15:0] mode_reg;
    logic        [15:0] clock_reg;
    logic        [7:0]  newFlags_reg;
    logic               resetFlag_reg;
    logic        [7:0]  intStatus_reg;
    logic        [7:0]  intMask_reg;
    logic        [31:0] prdata_reg;
    logic        [7:0]  idx;
    logic               mapped;
    logic               wrAccess;
    logic               rdSetup;
    logic        [7:0]  chanEvent;
    logic               pending;
    logic               pending_reg;
    logic        [7:0]  pulseCnt_reg;
    logic               pulseOn;
    logic               assertActive;

    assign idx      = regIndex(paddr);
    assign mapped   = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0)
                   && (idx == IDX_STATUS || idx == IDX_MODE
                   || idx == IDX_CLOCK || idx == IDX_INT_STATUS
                   || idx == IDX_INT_MASK);
    assign wrAccess = psel && penable && pwrite && mapped;
    assign rdSetup  = psel && !penable && !pwrite;
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign prdata   = prdata_reg;

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= 32'h0;
        end else if (rdSetup) begin
            case (idx)
                IDX_STATUS: prdata_reg <= {21'h0, resetFlag_reg,
                                           2'h0, newFlags_reg};
                IDX_MODE:       prdata_reg <= {16'h0, mode_reg};
                IDX_CLOCK:      prdata_reg <= {16'h0, clock_reg};
                IDX_INT_STATUS: prdata_reg <= {24'h0, intStatus_reg};
                IDX_INT_MASK:   prdata_reg <= {24'h0, intMask_reg};
                default:        prdata_reg <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // mode register
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mode_reg <= MODE_RESET;
        end else if (wrAccess && idx == IDX_MODE) begin
            // reserved bits are not stored and read zero
            mode_reg <= pwdata[15:0] & MODE_WR_MASK;
        end
    end

    assign modeCfg.regCrcEnable        = mode_reg[MODE_REG_CRC];
    assign modeCfg.rxCrcEnable         = mode_reg[MODE_RX_CRC];
    assign modeCfg.crcAnsi             = mode_reg[MODE_CRC_TYPE];
    assign modeCfg.word_size_select    = mode_reg[MODE_WLEN_LSB +: 2];
    assign modeCfg.timeoutEnable       = mode_reg[MODE_TIMEOUT];
    assign modeCfg.ready_source_select = mode_reg[MODE_SEL_LSB +: 2];
    assign modeCfg.ready_idle_float    = mode_reg[MODE_IDLE_HIZ];
    assign modeCfg.ready_pulse_format  = mode_reg[MODE_PULSE_FMT];

    // ----------------------------------------
    // clock register
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clock_reg <= CLOCK_RESET;
        end else if (wrAccess && idx == IDX_CLOCK) begin
            clock_reg <= pwdata[15:0];
        end
    end

    assign channelEnable = clock_reg[CLOCK_EN_LSB +: 8];

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resetFlag_reg <= 1'b1;
        end else if (wrAccess && idx == IDX_MODE
                     && !pwdata[MODE_RESET_BIT]) begin
            resetFlag_reg <= 1'b0;
        end
    end

    // a strobe in the service cycle wins over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            newFlags_reg <= 8'h00;
        end else begin
            newFlags_reg <= (dataServiced ? 8'h00 : newFlags_reg)
                          | sampleStrobe;
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    assign chanEvent = sampleStrobe & channelEnable;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            intStatus_reg <= 8'h00;
        end else if (wrAccess && idx == IDX_INT_STATUS) begin
            intStatus_reg <= (intStatus_reg & ~pwdata[7:0]) | chanEvent;
        end else begin
            intStatus_reg <= intStatus_reg | chanEvent;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            intMask_reg <= 8'h00;
        end else if (wrAccess && idx == IDX_INT_MASK) begin
            intMask_reg <= pwdata[7:0];
        end
    end

    assign irq = |(intStatus_reg & intMask_reg);

    // ----------------------------------------
    // ready pin
    // ----------------------------------------
    assign pending = readyPending(modeCfg.ready_source_select,
                                  newFlags_reg, channelEnable);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_reg <= 1'b0;
        end else begin
            pending_reg <= pending;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulseCnt_reg <= 8'h00;
        end else if (pending && !pending_reg) begin
            pulseCnt_reg <= 8'(READY_PULSE_CYCLES);
        end else if (pulseCnt_reg != 8'h00) begin
            pulseCnt_reg <= pulseCnt_reg - 8'h01;
        end
    end

    assign pulseOn      = pulseCnt_reg != 8'h00;
    assign assertActive = modeCfg.ready_pulse_format ? pulseOn
                                                     : pending;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dataReadyPinOut <= 1'b1;
            dataReadyPinOe  <= 1'b1;
        end else if (assertActive) begin
            dataReadyPinOut <= 1'b0;
            dataReadyPinOe  <= 1'b1;
        end else begin
            dataReadyPinOut <= 1'b1;
            dataReadyPinOe  <= !modeCfg.ready_idle_float;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    modeReset_a: assert property (@(posedge clk)
        $fell(reset) |-> mode_reg == MODE_RESET)
        else $error("mode register not at reset value");

    clockReset_a: assert property (@(posedge clk)
        $fell(reset) |-> clock_reg == CLOCK_RESET)
        else $error("clock register not at reset value");

    modeWrite_a: assert property (@(posedge clk) disable iff (reset)
        wrAccess && idx == IDX_MODE
        |=> mode_reg == ($past(pwdata[15:0]) & MODE_WR_MASK))
        else $error("mode write not stored");

    resetClear_a: assert property (@(posedge clk) disable iff (reset)
        wrAccess && idx == IDX_MODE && !pwdata[MODE_RESET_BIT]
        |=> !resetFlag_reg)
        else $error("reset flag not cleared");

    resetHold_a: assert property (@(posedge clk) disable iff (reset)
        resetFlag_reg && !(wrAccess && idx == IDX_MODE)
        |=> resetFlag_reg)
        else $error("reset flag lost without a clear");

    flagSet_a: assert property (@(posedge clk) disable iff (reset)
        sampleStrobe[0] |=> newFlags_reg[0])
        else $error("new data flag not set");

    levelLow_a: assert property (@(posedge clk) disable iff (reset)
        pending && !modeCfg.ready_pulse_format
        |=> !dataReadyPinOut && dataReadyPinOe)
        else $error("ready pin not held low");

    pulseLen_a: assert property (@(posedge clk) disable iff (reset)
        $rose(pulseOn) |-> ##PulseLen !pulseOn)
        else $error("ready pulse length wrong");

    idleFloat_a: assert property (@(posedge clk) disable iff (reset)
        !assertActive && modeCfg.ready_idle_float
        |=> !dataReadyPinOe)
        else $error("ready pin not floating when idle");

    disabledMute_a: assert property (@(posedge clk) disable iff (reset)
        (newFlags_reg & channelEnable) == 8'h00 |-> !pending)
        else $error("disabled channel drives ready");

    irqLevel_a: assert property (@(posedge clk) disable iff (reset)
        $rose(intStatus_reg[0]) && intMask_reg[0] |-> irq)
        else $error("interrupt not raised");

    pulseSeen_c: cover property (@(posedge clk) disable iff (reset)
        modeCfg.ready_pulse_format && $rose(pulseOn));
    lagging_c: cover property (@(posedge clk) disable iff (reset)
        modeCfg.ready_source_select == SRC_LAGGING && $rose(pending));
    resetClr_c: cover property (@(posedge clk) disable iff (reset)
        $fell(resetFlag_reg));
    float_c: cover property (@(posedge clk) disable iff (reset)
        $fell(dataReadyPinOe));

endmodule : amc_config_regs

// File: core/amc_pkg.sv
// package of constants and types for the mode and clock configuration bank
// assumes an apb master on a single 40 MHz clock
package amc_pkg;

    // register indices, byte address is four times the index
    localparam logic [7:0]  IDX_STATUS     = 8'h01;
    localparam logic [7:0]  IDX_MODE       = 8'h02;
    localparam logic [7:0]  IDX_CLOCK      = 8'h03;
    localparam logic [7:0]  IDX_INT_STATUS = 8'h10;
    localparam logic [7:0]  IDX_INT_MASK   = 8'h11;

    // reset values and mode write mask
    localparam logic [15:0] MODE_RESET     = 16'h0510;
    localparam logic [15:0] CLOCK_RESET    = 16'hff0e;
    localparam logic [15:0] MODE_WR_MASK   = 16'h3f1f;

    // field positions
    localparam int MODE_REG_CRC   = 13;
    localparam int MODE_RX_CRC    = 12;
    localparam int MODE_CRC_TYPE  = 11;
    localparam int MODE_RESET_BIT = 10;
    localparam int MODE_WLEN_LSB  = 8;
    localparam int MODE_TIMEOUT   = 4;
    localparam int MODE_SEL_LSB   = 2;
    localparam int MODE_IDLE_HIZ  = 1;
    localparam int MODE_PULSE_FMT = 0;
    localparam int CLOCK_EN_LSB   = 8;
    localparam int STATUS_RESET   = 10;

    // ready pulse length in clock cycles
    localparam int READY_PULSE_CYCLES = 4;

    // ready source choices
    localparam logic [1:0] SRC_LAGGING = 2'h0;
    localparam logic [1:0] SRC_OR      = 2'h1;

    typedef struct packed {
        logic       regCrcEnable;
        logic       rxCrcEnable;
        logic       crcAnsi;
        logic [1:0] word_size_select;
        logic       timeoutEnable;
        logic [1:0] ready_source_select;
        logic       ready_idle_float;
        logic       ready_pulse_format;
    } amc_mode_t;

endpackage : amc_pkg

// File: testbench/amc_config_regs_tb.sv
// self-checking bench of the mode and clock configuration bank
// assumes an apb master and the sample source model on one 40 MHz clock
`timescale 1ns/10ps
module amc_config_regs_tb;
    import amc_pkg::*;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [31:0] rexp;
    } amc_row_t;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
    logic        dataServiced, dataReadyPinOut, dataReadyPinOe, irq;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0]  sampleStrobe, channelEnable;
    amc_mode_t   modeCfg;
    int          n_errors = 0;
    int          n_tests = 0;
    int          lowCount;
    amc_row_t    rows [6] = '{'{32'h08, 32'hffff, 32'h3f1f}, '{32'h08, 32'h0000, 32'h0000},
        '{32'h04, 32'hffff, 32'h0000}, '{32'h08, 32'h2a15, 32'h2a15},
        '{32'h0c, 32'h00ff, 32'h00ff}, '{32'h0c, 32'ha5f0, 32'ha5f0}};

    amc_config_regs i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleStrobe(sampleStrobe), .dataServiced(dataServiced),
        .modeCfg(modeCfg), .channelEnable(channelEnable), .dataReadyPinOut(dataReadyPinOut),
        .dataReadyPinOe(dataReadyPinOe), .irq(irq));
    amc_sample_source i_src (.clk(clk), .sampleStrobe(sampleStrobe),
        .dataServiced(dataServiced));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n == 50) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(nm, rd, exp);
    endtask : rdchk

    task automatic pinchk(input logic [7:0] m, input logic o, input logic oe);
        i_src.strobe(m);
        @(posedge clk);
        #1;
        check("pinOut", {31'h0, dataReadyPinOut}, {31'h0, o});
        check("pinOe", {31'h0, dataReadyPinOe}, {31'h0, oe});
    endtask : pinchk

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check("idlePin", {30'h0, dataReadyPinOut, dataReadyPinOe}, 32'h3);
        check("irq", {31'h0, irq}, 32'h0);
        rdchk("mode", 32'h08, 32'h0510);
        rdchk("clock", 32'h0c, 32'hff0e);
        rdchk("status", 32'h04, 32'h0400);
    endtask : do_reset

    task automatic close_out();
        if (n_errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        #1000000;
        n_errors++;
        close_out();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        do_reset();
        foreach (rows[i]) begin
            apb(1'b1, rows[i].addr, rows[i].wdata);
            rdchk("reg", rows[i].addr, rows[i].rexp);
            if (rows[i].addr == 32'h08) check("modeCfg", 32'(modeCfg), {22'h0,
                rows[i].wdata[13:11], rows[i].wdata[9:8], rows[i].wdata[4:0]});
            if (rows[i].addr == 32'h0c) check("chanEn", {24'h0, channelEnable},
                {24'h0, rows[i].wdata[15:8]});
        end
        apb(1'b0, 32'h20, 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        check("rdUnmapped", rd, 32'h0);
        apb(1'b1, 32'h44, 32'h0);
        i_src.strobe(8'h03);
        rdchk("intStatus", 32'h40, 32'h1);
        rdchk("flags", 32'h04, 32'h3);
        check("irqMasked", {31'h0, irq}, 32'h0);
        apb(1'b1, 32'h44, 32'h1);
        #1;
        check("irqSet", {31'h0, irq}, 32'h1);
        apb(1'b1, 32'h40, 32'h1);
        #1;
        check("irqClr", {31'h0, irq}, 32'h0);
        i_src.strobe(8'h01);
        #1;
        check("irqEvent", {31'h0, irq}, 32'h1);
        apb(1'b1, 32'h40, 32'h1);
        i_src.service();
        apb(1'b1, 32'h0c, 32'h0100);
        apb(1'b1, 32'h08, 32'h0004);
        pinchk(8'h02, 1'b1, 1'b1);
        pinchk(8'h01, 1'b0, 1'b1);
        i_src.service();
        apb(1'b1, 32'h0c, 32'h0500);
        apb(1'b1, 32'h08, 32'h0000);
        pinchk(8'h01, 1'b1, 1'b1);
        pinchk(8'h04, 1'b0, 1'b1);
        i_src.service();
        apb(1'b1, 32'h08, 32'h0008);
        pinchk(8'h01, 1'b0, 1'b1);
        i_src.service();
        apb(1'b1, 32'h08, 32'h0002);
        repeat (2) @(posedge clk);
        #1;
        check("floatOe", {31'h0, dataReadyPinOe}, 32'h0);
        pinchk(8'h05, 1'b0, 1'b1);
        i_src.service();
        apb(1'b1, 32'h08, 32'h0001);
        i_src.strobe(8'h05);
        lowCount = 0;
        repeat (10) begin
            @(posedge clk);
            #1;
            if (dataReadyPinOut === 1'b0) lowCount++;
        end
        check("pulseLen", 32'(lowCount), 32'(READY_PULSE_CYCLES));
        check("afterPulse", {31'h0, dataReadyPinOut}, 32'h1);
        i_src.service();
        do_reset();
        close_out();
    end
endmodule : amc_config_regs_tb

// File: testbench/amc_sample_source.sv
// sample source model: new-data strobes and service pulses of the channels
// assumes a single clk shared with the configuration bank
`timescale 1ns/10ps
module amc_sample_source (
    input  wire logic       clk,
    output logic      [7:0] sampleStrobe,
    output logic            dataServiced
);
    initial begin
        sampleStrobe = 8'h00;
        dataServiced = 1'b0;
    end

    // one-cycle pulse per request, changed only after a rising edge
    task automatic strobe(input logic [7:0] m);
        @(posedge clk);
        sampleStrobe <= m;
        @(posedge clk);
        sampleStrobe <= 8'h00;
    endtask : strobe

    task automatic service();
        @(posedge clk);
        dataServiced <= 1'b1;
        @(posedge clk);
        dataServiced <= 1'b0;
    endtask : service
endmodule : amc_sample_source
